// [bsil_boundary_scan.sv]
// Boundary-scan test access logic: package of constants and the top module.
// Assumes one free-running system clock; the tester's TCK, TMS and TDI pins
// and the crystal status levels arrive asynchronously and are synchronised.
//
// What this block does
// - Code 000 routes TDI to TDO through the 132-cell boundary register.
// - While external test is active, the core is held in reset.
// - Under external test, boundary cells drive, capture and steer device pins.
// - Code 001 captures system signals into the boundary register in capture-DR.
// - Sample/preload loads output cells ahead of external test.
// - Codes X1X and 101 route TDI to TDO through the one-bit bypass stage.
// - The bypass stage captures zero in capture-DR.
// - Code 100 floats every output driver and selects the bypass stage.
// - Power-up reset resets the test logic and holds it in test-logic-reset.
// - Leaving test-logic-reset forbids minimum power in low-power halt only.
// - The test clock keeps working during low-power halt.
// - Five rising test clocks with mode-select high force test-logic-reset.
// - Undriven mode-select and data-in read high, keeping test-logic-reset.
// - The instruction register is three bits; outputs change only in update-IR and test-logic-reset.
// - Instruction outputs are set to all ones in test-logic-reset.
// - Capture-IR loads 01 low and the crystal-missing flag into bit 2.
// - Crystal-missing reads one only with a crystal source and no clock.

package bsil_pkg;

   // ******************************************************************
   // Sizes, codes and reset values
   // ******************************************************************
   localparam int BSIL_BSR_LEN = 132;
   localparam int BSIL_IR_LEN = 3;
   localparam int BSIL_TLR_TMS_COUNT = 5;
   localparam logic [2:0] BSIL_IR_EXTEST = 3'h0;
   localparam logic [2:0] BSIL_IR_SAMPLE = 3'h1;
   localparam logic [2:0] BSIL_IR_FLOAT = 3'h4;
   localparam logic [2:0] BSIL_IR_RESET = 3'h7;
   localparam int BSIL_IR_BYPASS_BIT = 1;
   localparam logic [1:0] BSIL_IR_CAPTURE_LOW = 2'h1;

   // ******************************************************************
   // Types
   // ******************************************************************
   typedef enum logic [3:0] {
      BSIL_TLR = 4'hF,
      BSIL_RTI = 4'hC,
      BSIL_SEL_DR = 4'h7,
      BSIL_CAP_DR = 4'h6,
      BSIL_SH_DR = 4'h2,
      BSIL_EX1_DR = 4'h1,
      BSIL_PA_DR = 4'h3,
      BSIL_EX2_DR = 4'h0,
      BSIL_UP_DR = 4'h5,
      BSIL_SEL_IR = 4'h4,
      BSIL_CAP_IR = 4'hE,
      BSIL_SH_IR = 4'hA,
      BSIL_EX1_IR = 4'h9,
      BSIL_PA_IR = 4'hB,
      BSIL_EX2_IR = 4'h8,
      BSIL_UP_IR = 4'hD
   } bsil_tap_e;

   typedef enum logic [1:0] {
      BSIL_I_EXTEST = 2'h0,
      BSIL_I_SAMPLE = 2'h1,
      BSIL_I_BYPASS = 2'h2,
      BSIL_I_FLOAT = 2'h3
   } bsil_instr_e;

   // Test-port pins as seen by the system clock.
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } bsil_pins_s;

   // One-cycle commands to the boundary register.
   typedef struct packed {
      logic capture;
      logic shift;
      logic update;
      logic tdi;
   } bsil_dr_cmd_s;

   // ******************************************************************
   // Controller sequence and instruction decode
   // ******************************************************************
   function automatic bsil_tap_e bsil_tap_next(input bsil_tap_e s,
                                               input logic tms);
      bsil_tap_e n;
      n = s;
      unique case (s)
         BSIL_TLR: n = tms ? BSIL_TLR : BSIL_RTI;
         BSIL_RTI: n = tms ? BSIL_SEL_DR : BSIL_RTI;
         BSIL_SEL_DR: n = tms ? BSIL_SEL_IR : BSIL_CAP_DR;
         BSIL_CAP_DR: n = tms ? BSIL_EX1_DR : BSIL_SH_DR;
         BSIL_SH_DR: n = tms ? BSIL_EX1_DR : BSIL_SH_DR;
         BSIL_EX1_DR: n = tms ? BSIL_UP_DR : BSIL_PA_DR;
         BSIL_PA_DR: n = tms ? BSIL_EX2_DR : BSIL_PA_DR;
         BSIL_EX2_DR: n = tms ? BSIL_UP_DR : BSIL_SH_DR;
         BSIL_UP_DR: n = tms ? BSIL_SEL_DR : BSIL_RTI;
         BSIL_SEL_IR: n = tms ? BSIL_TLR : BSIL_CAP_IR;
         BSIL_CAP_IR: n = tms ? BSIL_EX1_IR : BSIL_SH_IR;
         BSIL_SH_IR: n = tms ? BSIL_EX1_IR : BSIL_SH_IR;
         BSIL_EX1_IR: n = tms ? BSIL_UP_IR : BSIL_PA_IR;
         BSIL_PA_IR: n = tms ? BSIL_EX2_IR : BSIL_PA_IR;
         BSIL_EX2_IR: n = tms ? BSIL_UP_IR : BSIL_SH_IR;
         BSIL_UP_IR: n = tms ? BSIL_SEL_DR : BSIL_RTI;
      endcase
      return n;
   endfunction : bsil_tap_next

   function automatic bsil_instr_e bsil_decode(input logic [2:0] ir);
      bsil_instr_e d;
      if (ir[BSIL_IR_BYPASS_BIT]) begin
         d = BSIL_I_BYPASS;
      end else if (ir == BSIL_IR_EXTEST) begin
         d = BSIL_I_EXTEST;
      end else if (ir == BSIL_IR_SAMPLE) begin
         d = BSIL_I_SAMPLE;
      end else if (ir == BSIL_IR_FLOAT) begin
         d = BSIL_I_FLOAT;
      end else begin
         d = BSIL_I_BYPASS;
      end
      return d;
   endfunction : bsil_decode

endpackage : bsil_pkg

`timescale 1ns/10ps

module bsil_top
   import bsil_pkg::*;
#(
   parameter int BSR_LEN = BSIL_BSR_LEN
) (
   // System clock and power-up reset
   input wire logic i_mclk,
   input wire logic i_arst_n,
   // Test port pins from the tester
   input wire logic i_tck,
   input wire logic i_tms,
   input wire logic i_tdi,
   // Clock source status
   input wire logic i_xtal_mode,
   input wire logic i_clock_detected,
   // Pin and system levels captured into the boundary cells
   input wire logic [BSR_LEN-1:0] i_bsr_capture,
   // Test data out
   output logic o_tdo,
   output logic o_tdo_oe,
   // Control of the device core and pins
   output logic o_core_reset,
   output logic o_extest,
   output logic o_outputs_float,
   output logic o_min_power_ok,
   output logic [BSR_LEN-1:0] o_bsr_drive
);

   // ******************************************************************
   // State
   // ******************************************************************
   typedef struct packed {
      logic [2:0] tck_sync;
      logic [1:0] tms_sync;
      logic [1:0] tdi_sync;
      logic [1:0] xtal_sync;
      logic [1:0] clkdet_sync;
      bsil_tap_e tap;
      logic [BSIL_IR_LEN-1:0] ir_shift;
      logic [BSIL_IR_LEN-1:0] ir;
      logic bypass;
      logic tdo;
      logic tdo_oe;
      logic core_reset;
      logic extest;
      logic outputs_float;
      logic min_power_ok;
   } bsil_state_s;

   bsil_state_s st;
   bsil_state_s next_st;
   bsil_pins_s pin;
   bsil_dr_cmd_s dr_cmd;
   bsil_instr_e instr;
   logic rise;
   logic fall;
   logic bsr_sel;
   logic bsr_so;
   logic crystal_clock_missing;

   // Only the second synchroniser flop and its delayed copy are looked at.
   assign pin.tck = st.tck_sync[1];
   assign pin.tms = st.tms_sync[1];
   assign pin.tdi = st.tdi_sync[1];
   assign rise = pin.tck & ~st.tck_sync[2];
   assign fall = ~pin.tck & st.tck_sync[2];
   assign instr = bsil_decode(st.ir);
   assign bsr_sel = (instr == BSIL_I_EXTEST) || (instr == BSIL_I_SAMPLE);
   assign crystal_clock_missing = st.xtal_sync[1] & ~st.clkdet_sync[1];

   assign dr_cmd.capture = rise && (st.tap == BSIL_CAP_DR) && bsr_sel;
   assign dr_cmd.shift = rise && (st.tap == BSIL_SH_DR) && bsr_sel;
   assign dr_cmd.update = fall && (st.tap == BSIL_UP_DR) && bsr_sel;
   assign dr_cmd.tdi = pin.tdi;

   // ******************************************************************
   // Next state
   // ******************************************************************
   always_comb begin
      next_st = st;
      next_st.tck_sync = {st.tck_sync[1:0], i_tck};
      next_st.tms_sync = {st.tms_sync[0], i_tms};
      next_st.tdi_sync = {st.tdi_sync[0], i_tdi};
      next_st.xtal_sync = {st.xtal_sync[0], i_xtal_mode};
      next_st.clkdet_sync = {st.clkdet_sync[0], i_clock_detected};
      // Held-high mode-select never leaves reset, whatever TCK does.
      if (rise) begin
         next_st.tap = bsil_tap_next(st.tap, pin.tms);
         unique case (st.tap)
            BSIL_CAP_IR: begin
               next_st.ir_shift = {crystal_clock_missing,
                                   BSIL_IR_CAPTURE_LOW};
            end
            BSIL_SH_IR: begin
               next_st.ir_shift = {pin.tdi, st.ir_shift[2:1]};
            end
            BSIL_CAP_DR: begin
               if (!bsr_sel) begin
                  next_st.bypass = 1'b0;
               end
            end
            BSIL_SH_DR: begin
               if (!bsr_sel) begin
                  next_st.bypass = pin.tdi;
               end
            end
            default: begin
            end
         endcase
      end
      if (fall) begin
         if (st.tap == BSIL_UP_IR) begin
            next_st.ir = st.ir_shift;
         end
         // Driving only while shifting leaves the TDO net free otherwise.
         next_st.tdo_oe = (st.tap == BSIL_SH_DR) || (st.tap == BSIL_SH_IR);
         if (st.tap == BSIL_SH_IR) begin
            next_st.tdo = st.ir_shift[0];
         end else if (st.tap == BSIL_SH_DR) begin
            next_st.tdo = bsr_sel ? bsr_so : st.bypass;
         end else begin
            next_st.tdo = 1'b0;
         end
      end
      if (st.tap == BSIL_TLR) begin
         next_st.ir = BSIL_IR_RESET;
      end
      next_st.core_reset = (instr == BSIL_I_EXTEST);
      next_st.extest = (instr == BSIL_I_EXTEST);
      next_st.outputs_float = (instr == BSIL_I_FLOAT);
      next_st.min_power_ok = (st.tap == BSIL_TLR);
   end

   // Power-up reset forces test-logic-reset; the controller moves only
   // after release. The pull-ups on TMS and TDI are reset high here too.
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st <= '0;
         st.tck_sync <= 3'h7;
         st.tms_sync <= 2'h3;
         st.tdi_sync <= 2'h3;
         st.tap <= BSIL_TLR;
         st.ir_shift <= BSIL_IR_RESET;
         st.ir <= BSIL_IR_RESET;
         st.min_power_ok <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ******************************************************************
   // Boundary register
   // ******************************************************************
   bsil_bscan_reg #(
      .LEN(BSR_LEN)
   ) u_bsr (
      .i_mclk(i_mclk),
      .i_arst_n(i_arst_n),
      .i_cmd(dr_cmd),
      .i_capture(i_bsr_capture),
      .o_so(bsr_so),
      .o_drive(o_bsr_drive)
   );

   assign o_tdo = st.tdo;
   assign o_tdo_oe = st.tdo_oe;
   assign o_core_reset = st.core_reset;
   assign o_extest = st.extest;
   assign o_outputs_float = st.outputs_float;
   assign o_min_power_ok = st.min_power_ok;

   // ******************************************************************
   // Assertions
   // ******************************************************************
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_arst_n);

   logic [2:0] tms_high_cnt;
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tms_high_cnt <= 3'h0;
      end else if (rise) begin
         if (!pin.tms) begin
            tms_high_cnt <= 3'h0;
         end else if (tms_high_cnt != 3'(BSIL_TLR_TMS_COUNT)) begin
            tms_high_cnt <= tms_high_cnt + 3'h1;
         end
      end
   end

   sequence s_cap_ir;
      rise && (st.tap == BSIL_CAP_IR);
   endsequence
   sequence s_ir_loaded;
      (st.ir_shift[1:0] == BSIL_IR_CAPTURE_LOW) && $stable(st.ir);
   endsequence

   property p_five_tms;
      tms_high_cnt == 3'(BSIL_TLR_TMS_COUNT) |-> st.tap == BSIL_TLR;
   endproperty
   a_five_tms: assert property (p_five_tms) else $error("no reset after five TMS highs");

   property p_ir_ones;
      st.tap == BSIL_TLR |=> st.ir == BSIL_IR_RESET;
   endproperty
   a_ir_ones: assert property (p_ir_ones) else $error("instruction not all ones");

   property p_core_reset;
      st.ir == BSIL_IR_EXTEST |=> o_core_reset && o_extest;
   endproperty
   a_core_reset: assert property (p_core_reset) else $error("core not held in reset");

   property p_float;
      st.ir == BSIL_IR_FLOAT |-> !bsr_sel ##1 (o_outputs_float && !o_extest);
   endproperty
   a_float: assert property (p_float) else $error("outputs not floated");

   property p_bypass_zero;
      rise && st.tap == BSIL_CAP_DR && !bsr_sel |=> !st.bypass;
   endproperty
   a_bypass_zero: assert property (p_bypass_zero) else $error("bypass not cleared");

   property p_ir_capture;
      s_cap_ir |=> s_ir_loaded ##0
         (st.ir_shift[2] == $past(crystal_clock_missing));
   endproperty
   a_ir_capture: assert property (p_ir_capture) else $error("bad capture-IR value");

   property p_loc_ext;
      s_cap_ir ##0 !st.xtal_sync[1] |=> !st.ir_shift[2];
   endproperty
   a_loc_ext: assert property (p_loc_ext) else $error("crystal flag set on external clock");

   property p_ir_update;
      fall && st.tap == BSIL_UP_IR |=> st.ir == $past(st.ir_shift);
   endproperty
   a_ir_update: assert property (p_ir_update) else $error("instruction not updated");

   property p_tdo_idle;
      fall && st.tap != BSIL_SH_DR && st.tap != BSIL_SH_IR |=> !o_tdo_oe;
   endproperty
   a_tdo_idle: assert property (p_tdo_idle) else $error("TDO driven outside shift");

   property p_min_power;
      st.tap != BSIL_TLR |=> !o_min_power_ok;
   endproperty
   a_min_power: assert property (p_min_power) else $error("min power allowed outside reset");

endmodule : bsil_top

// [bsil_bscan_reg.sv]
// Boundary scan register: capture, shift and update stages of all cells.
// Assumes one-cycle commands on the system clock from the test controller.
`timescale 1ns/10ps

module bsil_bscan_reg
   import bsil_pkg::*;
#(
   parameter int LEN = BSIL_BSR_LEN
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_arst_n,
   // Commands and parallel capture levels
   input wire bsil_dr_cmd_s i_cmd,
   input wire logic [LEN-1:0] i_capture,
   // Serial out and update latches
   output logic o_so,
   output logic [LEN-1:0] o_drive
);

   typedef struct packed {
      logic [LEN-1:0] sh;
      logic [LEN-1:0] upd;
   } bsil_bsr_s;

   bsil_bsr_s st;
   bsil_bsr_s next_st;

   // Update latches hold preloaded values so external test drives them at
   // once; they change only on update, never while shifting.
   always_comb begin
      next_st = st;
      if (i_cmd.capture) begin
         next_st.sh = i_capture;
      end else if (i_cmd.shift) begin
         next_st.sh = {i_cmd.tdi, st.sh[LEN-1:1]};
      end
      if (i_cmd.update) begin
         next_st.upd = st.sh;
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_so = st.sh[0];
   assign o_drive = st.upd;

endmodule : bsil_bscan_reg

// [bsil_tester.sv]
// Partner model: a board tester that drives the test port pins.
// Assumes the bench adds the pull-ups on mode-select and data-in.
`timescale 1ns/10ps

module bsil_tester (
   // Pacing clock
   input wire logic i_mclk,
   // Test data out from the device
   input wire logic i_tdo,
   input wire logic i_tdo_oe,
   // Test port pins and their drive enable
   output logic o_tck,
   output logic o_tms,
   output logic o_tdi,
   output logic o_oe
);
   // ******************************************************************
   // Test clock periods
   // ******************************************************************
   initial begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b1;
      o_oe = 1'b0;
   end

   // Pins change only on system clock edges, so that sampled system data
   // lines up with that clock. The tester drives only its own pins and
   // never a net that the device drives.
   task automatic step(input logic drv, tms, tdi, output logic tdo, oe);
      o_oe = drv;
      o_tms = tms;
      o_tdi = tdi;
      repeat (4) @(negedge i_mclk);
      tdo = i_tdo;
      oe = i_tdo_oe;
      o_tck = 1'b1;
      repeat (4) @(negedge i_mclk);
      o_tck = 1'b0;
   endtask : step

   task automatic walk(input logic [7:0] tmsv, input int n);
      logic d, e;
      for (int i = 0; i < n; i++) begin
         step(1'b1, tmsv[i], 1'b0, d, e);
      end
   endtask : walk

   // Shifts n bits, lowest first, leaving the controller in exit-1.
   task automatic shift(input int n, input logic [131:0] din,
                        output logic [131:0] dout, output logic oe_all);
      logic d, e;
      dout = '0;
      oe_all = 1'b1;
      for (int i = 0; i < n; i++) begin
         step(1'b1, logic'(i == n - 1), din[i], d, e);
         dout[i] = d;
         oe_all = oe_all & e;
      end
   endtask : shift

endmodule : bsil_tester

// [bsil_top_tb.sv]
// Testbench of the boundary-scan test logic with a tester model.
// Assumes a 100 MHz system clock and an 80 ns test clock period.
`timescale 1ns/10ps

module bsil_top_tb;
   import bsil_pkg::*;

   logic i_mclk;
   logic i_arst_n;
   logic xtal_mode;
   logic clock_detected;
   logic [BSIL_BSR_LEN-1:0] capture;
   logic [BSIL_BSR_LEN-1:0] drive;
   logic [BSIL_BSR_LEN-1:0] got;
   logic tck, tms, tdi, pin_oe, tdo, tdo_oe, got_oe, d, e;
   logic core_reset, extest, outputs_float, min_power_ok;
   int error_cnt = 0;
   int samples_checked = 0;
   int cycles = 0;

   // Released pins float high through the on-chip pull-ups.
   wire tms_pin = pin_oe ? tms : 1'b1;
   wire tdi_pin = pin_oe ? tdi : 1'b1;

   bsil_top #(.BSR_LEN(BSIL_BSR_LEN)) i_bsil_top (
      .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_tck(tck), .i_tms(tms_pin),
      .i_tdi(tdi_pin), .i_xtal_mode(xtal_mode),
      .i_clock_detected(clock_detected), .i_bsr_capture(capture),
      .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_core_reset(core_reset),
      .o_extest(extest), .o_outputs_float(outputs_float),
      .o_min_power_ok(min_power_ok), .o_bsr_drive(drive));

   bsil_tester i_bsil_tester (
      .i_mclk(i_mclk), .i_tdo(tdo), .i_tdo_oe(tdo_oe),
      .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_oe(pin_oe));

   // ******************************************************************
   // Clock, watchdog and shared tasks
   // ******************************************************************
   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end

   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         conclude();
      end
   end

   task automatic check(input string name, input logic [131:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude

   task automatic ir(input logic [2:0] code, output logic [2:0] cap);
      i_bsil_tester.walk(8'h03, 4);
      i_bsil_tester.shift(3, 132'(code), got, got_oe);
      cap = got[2:0];
      check("ir tdo enable", got_oe, 1'b1);
      i_bsil_tester.walk(8'h01, 2);
   endtask : ir

   task automatic dr(input int n, input logic [131:0] din);
      i_bsil_tester.walk(8'h01, 3);
      i_bsil_tester.shift(n, din, got, got_oe);
      check("dr tdo enable", got_oe, 1'b1);
      i_bsil_tester.walk(8'h01, 2);
   endtask : dr

   // ******************************************************************
   // Scenarios
   // ******************************************************************
   task automatic t_idle();
      repeat (6) i_bsil_tester.step(1'b0, 1'b0, 1'b0, d, e);
      check("released pins", min_power_ok, 1'b1);
      i_bsil_tester.walk(8'h00, 1);
      check("left reset state", min_power_ok, 1'b0);
      i_bsil_tester.walk(8'h01, 3);
      i_bsil_tester.walk(8'h0F, 4);
      check("four high", min_power_ok, 1'b0);
      i_bsil_tester.walk(8'h01, 1);
      check("five high", min_power_ok, 1'b1);
      i_bsil_tester.walk(8'h00, 1);
      $display("test idle done");
   endtask : t_idle

   task automatic t_crystal();
      logic [2:0] cap;
      for (int k = 0; k < 4; k++) begin
         xtal_mode = k[1];
         clock_detected = k[0];
         ir(3'h7, cap);
         check("ir capture", cap, {k[1] & ~k[0], 2'h1});
      end
      $display("test crystal done");
   endtask : t_crystal

   task automatic t_bypass();
      logic [2:0] codes [6] = '{3'h2, 3'h3, 3'h6, 3'h7, 3'h5, 3'h4};
      logic [2:0] cap;
      foreach (codes[j]) begin
         ir(codes[j], cap);
         dr(8, 132'hB5);
         check("bypass path", got, 132'h6A);
         check("float", outputs_float, codes[j] == 3'h4);
         check("no extest", extest, 1'b0);
      end
      $display("test bypass done");
   endtask : t_bypass

   task automatic t_extest();
      logic [2:0] cap;
      capture = {33{4'hA}};
      ir(BSIL_IR_SAMPLE, cap);
      dr(BSIL_BSR_LEN, {33{4'h3}});
      check("sample capture", got, {33{4'hA}});
      check("preload", drive, {33{4'h3}});
      check("sample core", core_reset, 1'b0);
      check("sample pins", extest, 1'b0);
      check("sample float", outputs_float, 1'b0);
      capture = {33{4'hE}};
      i_bsil_tester.walk(8'h03, 4);
      i_bsil_tester.shift(3, 132'(BSIL_IR_EXTEST), got, got_oe);
      check("ir before update", extest, 1'b0);
      i_bsil_tester.walk(8'h01, 2);
      check("extest pins", extest, 1'b1);
      check("extest core", core_reset, 1'b1);
      check("preload kept", drive, {33{4'h3}});
      dr(BSIL_BSR_LEN, {11{12'h1F4}});
      check("extest capture", got, {33{4'hE}});
      check("extest drive", drive, {11{12'h1F4}});
      $display("test extest done");
   endtask : t_extest

   task automatic t_reset();
      // Test clocks while reset is held must leave the controller alone.
      i_arst_n = 1'b0;
      i_bsil_tester.step(1'b1, 1'b0, 1'b0, d, e);
      i_bsil_tester.step(1'b1, 1'b0, 1'b0, d, e);
      check("min power in reset", min_power_ok, 1'b1);
      check("extest in reset", extest, 1'b0);
      check("core in reset", core_reset, 1'b0);
      check("drive in reset", drive, '0);
      i_arst_n = 1'b1;
      repeat (4) @(negedge i_mclk);
      i_bsil_tester.walk(8'h00, 1);
      dr(8, 132'hB5);
      check("bypass after reset", got, 132'h6A);
      $display("test reset done");
   endtask : t_reset

   initial begin
      i_arst_n = 1'b0;
      xtal_mode = 1'b0;
      clock_detected = 1'b0;
      capture = '0;
      repeat (10) @(negedge i_mclk);
      i_arst_n = 1'b1;
      repeat (4) @(negedge i_mclk);
      t_idle();
      t_crystal();
      t_bypass();
      t_extest();
      t_reset();
      conclude();
   end

endmodule : bsil_top_tb
